// >>> hdl/caiu_core.sv
`timescale 1ns/1ps
`default_nettype none
module caiu_core
  import caiu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Memory access request from the execution unit
  input wire caiu_acc_t acc_kind,
  input wire logic bp_base,
  input wire logic override_en,
  input wire caiu_seg_t override_seg,
  input wire caiu_disp_t disp_kind,
  input wire logic [15:0] disp,
  input wire logic base_en,
  input wire logic base_sel_bp,
  input wire logic index_en,
  input wire logic index_sel_di,
  input wire logic [15:0] base_general_reg,
  input wire logic [15:0] base_pointer_reg,
  input wire logic [15:0] source_index_reg,
  input wire logic [15:0] destination_index_reg,
  input wire logic [15:0] extra_segment_reg,
  input wire logic [15:0] stack_segment_reg,
  input wire logic [15:0] data_segment_reg,
  // Memory address result
  output logic [15:0] eff_addr_ff,
  output logic [19:0] mem_addr_ff,
  output caiu_seg_t seg_used_ff,
  // I/O port addressing
  input wire logic port_from_reg,
  input wire logic [7:0] port_imm,
  input wire logic [15:0] port_number_reg,
  output logic [15:0] port_addr_ff,
  // Instruction boundary and event sources
  input wire logic instr_end,
  input wire logic [15:0] next_ip,
  input wire logic [15:0] instr_start_ip,
  input wire logic divide_overflow,
  input wire logic escape_trap,
  input wire logic escape_has_prefix,
  input wire logic [15:0] prefix_ip,
  input wire logic soft_int,
  input wire logic [7:0] soft_type,
  input wire logic other_exc,
  input wire logic [7:0] other_exc_type,
  input wire logic step_skip,
  input wire logic nmi_req,
  input wire logic intr_req,
  input wire logic intr_internal,
  input wire logic [7:0] intr_internal_type,
  // Flag and code segment writes from execution
  input wire logic flags_wr,
  input wire logic [15:0] flags_wdata,
  input wire logic cs_wr,
  input wire logic [15:0] cs_wdata,
  // Bus sequence for acknowledge, pushes and table reads
  output logic bus_req,
  output logic bus_write,
  output logic bus_ack_cycle,
  output logic [19:0] bus_addr_ff,
  output logic [15:0] bus_wdata_ff,
  input wire logic bus_done,
  input wire logic [15:0] bus_rdata,
  // Architectural state out
  output logic [15:0] status_word_ff,
  output logic [15:0] code_segment_ff,
  output logic [15:0] instruction_pointer_ff,
  output logic [15:0] stack_ptr_ff,
  output logic [7:0] vector_ff,
  output logic busy
);
  caiu_state_t state_ff, nxt_state;
  logic [15:0] ret_ip_ff, nxt_ret_ip;
  logic [15:0] saved_flags_ff;
  logic [7:0] nxt_vector;
  logic [15:0] nxt_flags;
  logic [15:0] nxt_cs;
  logic [15:0] nxt_ip;
  logic [15:0] nxt_sp;
  logic [19:0] nxt_bus_addr;
  logic [15:0] nxt_bus_wdata;

  wire caiu_seg_t seg_comb;
  wire logic [15:0] ea_comb;
  wire logic [19:0] pa_comb;

  caiu_addr_gen u_addr (
    .acc_kind(acc_kind),
    .bp_base(bp_base),
    .override_en(override_en),
    .override_seg(override_seg),
    .disp_kind(disp_kind),
    .disp(disp),
    .base_en(base_en),
    .base_sel_bp(base_sel_bp),
    .index_en(index_en),
    .index_sel_di(index_sel_di),
    .base_general_reg(base_general_reg),
    .base_pointer_reg(base_pointer_reg),
    .source_index_reg(source_index_reg),
    .destination_index_reg(destination_index_reg),
    .extra_segment_reg(extra_segment_reg),
    .code_segment_reg(code_segment_ff),
    .stack_segment_reg(stack_segment_reg),
    .data_segment_reg(data_segment_reg),
    .eff_addr(ea_comb),
    .seg_used(seg_comb),
    .phys_addr(pa_comb)
  );

  function automatic logic [19:0] seg_phys(input logic [15:0] seg, input logic [15:0] off);
    seg_phys = 20'({seg, 4'h0} + {4'h0, off});
  endfunction

  // Event decode, only at a boundary and only while idle
  wire logic idle = (state_ff == ST_IDLE);
  wire logic take = idle && instr_end;
  wire logic ev_div = take && divide_overflow;
  wire logic ev_esc = take && escape_trap;
  wire logic ev_exc = take && other_exc;
  wire logic ev_soft = take && soft_int;
  wire logic instr_ev = ev_div || ev_esc || ev_exc || ev_soft;
  wire logic ev_step = take && !instr_ev && status_word_ff[FLAG_STEP] && !step_skip;
  // Instruction-raised events beat hardware sampled at the boundary
  wire logic hw_ok = take && !instr_ev && !ev_step;
  wire logic ev_nmi = hw_ok && nmi_req;
  wire logic ev_intr = hw_ok && !nmi_req && intr_req && status_word_ff[FLAG_IEN];
  wire logic ev_any = instr_ev || ev_step || ev_nmi || ev_intr;

  // Internal vectors need no acknowledge cycle
  wire logic [7:0] int_vec = ev_div ? VEC_DIVIDE :
    ev_esc ? VEC_ESCAPE :
    ev_exc ? other_exc_type :
    ev_soft ? soft_type :
    ev_step ? VEC_STEP :
    ev_nmi ? VEC_NMI : intr_internal_type;
  wire logic need_ack = ev_intr && !intr_internal;

  // Escape returns to itself or its prefix; others return past
  wire logic [15:0] ret_sel = ev_esc ? (escape_has_prefix ? prefix_ip : instr_start_ip) :
    next_ip;

  wire logic [15:0] sp_dec = 16'(stack_ptr_ff - TWO16);
  wire logic [19:0] push_addr = seg_phys(stack_segment_reg, sp_dec);
  // Table entry at type times four, pointer word then segment word
  wire logic [19:0] tbl_addr = 20'({12'h000, vector_ff} << VEC_SHIFT);
  wire logic [19:0] tbl_addr_hi = 20'(tbl_addr + 20'(TWO16));

  assign busy = !idle;
  assign bus_req = (state_ff != ST_IDLE) && (state_ff != ST_DONE);
  assign bus_write = (state_ff == ST_PUSH_FLAGS) || (state_ff == ST_PUSH_CS) ||
    (state_ff == ST_PUSH_IP);
  assign bus_ack_cycle = (state_ff == ST_ACK);

  always_comb begin
    nxt_state = state_ff;
    nxt_vector = vector_ff;
    nxt_ret_ip = ret_ip_ff;
    nxt_flags = flags_wr ? flags_wdata : status_word_ff;
    nxt_cs = cs_wr ? cs_wdata : code_segment_ff;
    nxt_ip = idle && instr_end ? next_ip : instruction_pointer_ff;
    nxt_sp = stack_ptr_ff;
    nxt_bus_addr = bus_addr_ff;
    nxt_bus_wdata = bus_wdata_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (ev_any) begin
          nxt_vector = int_vec;
          nxt_ret_ip = ret_sel;
          nxt_state = need_ack ? ST_ACK : ST_PUSH_FLAGS;
          nxt_bus_addr = push_addr;
          nxt_bus_wdata = nxt_flags;
        end
      end
      ST_ACK: begin
        if (bus_done) begin
          nxt_vector = bus_rdata[7:0];
          nxt_state = ST_PUSH_FLAGS;
        end
      end
      ST_PUSH_FLAGS: begin
        nxt_bus_addr = push_addr;
        nxt_bus_wdata = saved_flags_ff;
        if (bus_done) begin
          nxt_sp = sp_dec;
          // Enable and step cleared after the old flags are pushed
          nxt_flags[FLAG_IEN] = 1'b0;
          nxt_flags[FLAG_STEP] = 1'b0;
          nxt_bus_addr = seg_phys(stack_segment_reg, 16'(sp_dec - TWO16));
          nxt_bus_wdata = code_segment_ff;
          nxt_state = ST_PUSH_CS;
        end
      end
      ST_PUSH_CS: begin
        if (bus_done) begin
          nxt_sp = sp_dec;
          nxt_bus_addr = seg_phys(stack_segment_reg, 16'(sp_dec - TWO16));
          nxt_bus_wdata = ret_ip_ff;
          nxt_state = ST_PUSH_IP;
        end
      end
      ST_PUSH_IP: begin
        if (bus_done) begin
          nxt_sp = sp_dec;
          nxt_bus_addr = tbl_addr;
          nxt_state = ST_READ_IP;
        end
      end
      ST_READ_IP: begin
        if (bus_done) begin
          nxt_ip = bus_rdata;
          nxt_bus_addr = tbl_addr_hi;
          nxt_state = ST_READ_CS;
        end
      end
      ST_READ_CS: begin
        if (bus_done) begin
          nxt_cs = bus_rdata;
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      vector_ff <= ZERO8;
      ret_ip_ff <= IP_RST;
      saved_flags_ff <= FLAGS_RST;
      status_word_ff <= FLAGS_RST;
      code_segment_ff <= CS_RST;
      instruction_pointer_ff <= IP_RST;
      stack_ptr_ff <= SP_RST;
      bus_addr_ff <= 20'h00000;
      bus_wdata_ff <= ZERO16;
    end else begin
      state_ff <= nxt_state;
      vector_ff <= nxt_vector;
      ret_ip_ff <= nxt_ret_ip;
      if (idle) begin
        saved_flags_ff <= nxt_flags;
      end
      status_word_ff <= nxt_flags;
      code_segment_ff <= nxt_cs;
      instruction_pointer_ff <= nxt_ip;
      stack_ptr_ff <= nxt_sp;
      bus_addr_ff <= nxt_bus_addr;
      bus_wdata_ff <= nxt_bus_wdata;
    end
  end

  // Address and port outputs registered for timing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      eff_addr_ff <= ZERO16;
      mem_addr_ff <= 20'h00000;
      seg_used_ff <= SEG_DATA;
      port_addr_ff <= ZERO16;
    end else begin
      eff_addr_ff <= ea_comb;
      mem_addr_ff <= pa_comb;
      seg_used_ff <= seg_comb;
      // Reserved system ports are not filtered here
      port_addr_ff <= port_from_reg ? port_number_reg : {ZERO8, port_imm};
    end
  end
endmodule
`default_nettype wire

// >>> hdl/caiu_pkg.sv
package caiu_pkg;
  localparam int AW = 16;
  localparam int PW = 20;
  localparam int SEG_SHIFT = 4;
  localparam int VEC_SHIFT = 2;
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_STEP = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_ESCAPE = 8'h07;
  localparam int FLAG_STEP = 8;
  localparam int FLAG_IEN = 9;
  localparam logic [15:0] FLAGS_RST = 16'hF002;
  localparam logic [15:0] CS_RST = 16'hFFFF;
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] TWO16 = 16'h0002;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Segment selection codes
  typedef enum logic [1:0] {
    SEG_EXTRA = 2'b00,
    SEG_CODE = 2'b01,
    SEG_STACK = 2'b10,
    SEG_DATA = 2'b11
  } caiu_seg_t;

  // Access kinds as decoded by the sequencer
  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_STACK = 2'b01,
    ACC_STRING_DST = 2'b10,
    ACC_DATA = 2'b11
  } caiu_acc_t;

  // Displacement kind
  typedef enum logic [1:0] {
    DISP_NONE = 2'b00,
    DISP_8 = 2'b01,
    DISP_16 = 2'b10
  } caiu_disp_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ACK = 4'b0001,
    ST_PUSH_FLAGS = 4'b0010,
    ST_PUSH_CS = 4'b0011,
    ST_PUSH_IP = 4'b0100,
    ST_READ_IP = 4'b0101,
    ST_READ_CS = 4'b0110,
    ST_DONE = 4'b0111
  } caiu_state_t;
endpackage

// >>> hdl/caiu_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module caiu_addr_gen
  import caiu_pkg::*;
(
  // Access description
  input wire caiu_acc_t acc_kind,
  input wire logic bp_base,
  input wire logic override_en,
  input wire caiu_seg_t override_seg,
  // Offset elements
  input wire caiu_disp_t disp_kind,
  input wire logic [15:0] disp,
  input wire logic base_en,
  input wire logic base_sel_bp,
  input wire logic index_en,
  input wire logic index_sel_di,
  input wire logic [15:0] base_general_reg,
  input wire logic [15:0] base_pointer_reg,
  input wire logic [15:0] source_index_reg,
  input wire logic [15:0] destination_index_reg,
  // Segment registers
  input wire logic [15:0] extra_segment_reg,
  input wire logic [15:0] code_segment_reg,
  input wire logic [15:0] stack_segment_reg,
  input wire logic [15:0] data_segment_reg,
  // Results
  output logic [15:0] eff_addr,
  output caiu_seg_t seg_used,
  output logic [19:0] phys_addr
);
  wire caiu_seg_t implied_seg;
  wire logic [15:0] disp_ext;
  wire logic [15:0] base_val;
  wire logic [15:0] index_val;
  wire logic [15:0] seg_val;

  assign implied_seg = (acc_kind == ACC_FETCH) ? SEG_CODE :
    (acc_kind == ACC_STACK || bp_base) ? SEG_STACK :
    (acc_kind == ACC_STRING_DST) ? SEG_EXTRA : SEG_DATA;
  // Fetches keep the code segment even under a prefix
  assign seg_used = (override_en && acc_kind != ACC_FETCH) ? override_seg : implied_seg;

  assign disp_ext = (disp_kind == DISP_8) ? {{8{disp[7]}}, disp[7:0]} :
    (disp_kind == DISP_16) ? disp : ZERO16;
  assign base_val = !base_en ? ZERO16 : base_sel_bp ? base_pointer_reg : base_general_reg;
  assign index_val = !index_en ? ZERO16 :
    index_sel_di ? destination_index_reg : source_index_reg;
  // Any element combination covers all six memory modes
  assign eff_addr = 16'(disp_ext + base_val + index_val);

  assign seg_val = (seg_used == SEG_EXTRA) ? extra_segment_reg :
    (seg_used == SEG_CODE) ? code_segment_reg :
    (seg_used == SEG_STACK) ? stack_segment_reg : data_segment_reg;
  assign phys_addr = 20'({seg_val, 4'h0} + {4'h0, eff_addr});
endmodule
`default_nettype wire

// >>> bench/caiu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module caiu_checker
  import caiu_pkg::*;
(
  // Clock, reset and inputs
  input wire logic ref_clk,
  input wire logic reset,
  input wire caiu_acc_t acc_kind,
  input wire logic bp_base,
  input wire logic override_en,
  input wire caiu_seg_t override_seg,
  input wire logic [15:0] data_segment_reg,
  input wire logic port_from_reg,
  input wire logic [7:0] port_imm,
  input wire logic instr_end,
  input wire logic bus_done,
  input wire logic [15:0] bus_rdata,
  // Outputs
  input wire logic [15:0] eff_addr_ff,
  input wire logic [19:0] mem_addr_ff,
  input wire caiu_seg_t seg_used_ff,
  input wire logic [15:0] port_addr_ff,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_ack_cycle,
  input wire logic [19:0] bus_addr_ff,
  input wire logic [15:0] status_word_ff,
  input wire logic [7:0] vector_ff,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  fetch_code_a: assert property (acc_kind == ACC_FETCH |=> seg_used_ff == SEG_CODE)
    else $error("fetch not on code segment");
  stack_seg_a: assert property ((acc_kind == ACC_STACK || (acc_kind == ACC_DATA && bp_base))
    && !override_en |=> seg_used_ff == SEG_STACK) else $error("stack segment missed");
  string_dest_a: assert property (acc_kind == ACC_STRING_DST && !override_en
    |=> seg_used_ff == SEG_EXTRA) else $error("string destination segment wrong");
  override_seg_a: assert property (acc_kind == ACC_DATA && override_en
    |=> seg_used_ff == $past(override_seg)) else $error("override ignored");
  // Release edge skipped, outputs still hold reset values then
  phys_addr_a: assert property (acc_kind == ACC_DATA && !override_en && !bp_base
    && !reset |=> mem_addr_ff == {$past(data_segment_reg), 4'h0} + {4'h0, eff_addr_ff})
    else $error("physical address wrong");
  byte_port_a: assert property (!port_from_reg && !reset
    |=> port_addr_ff == {8'h00, $past(port_imm)}) else $error("byte port not zero extended");
  push_hold_a: assert property (bus_req && bus_write && !bus_done
    |=> bus_req && bus_write && $stable(bus_addr_ff)) else $error("push dropped early");
  table_read_a: assert property (bus_req && !bus_write && !bus_ack_cycle
    |-> bus_addr_ff[19:10] == 10'h000 && bus_addr_ff[9:2] == vector_ff)
    else $error("table address wrong");
  ack_latch_a: assert property (bus_ack_cycle && bus_done
    |=> vector_ff == $past(bus_rdata[7:0])) else $error("acknowledge vector not latched");
  boundary_a: assert property ($rose(busy) |-> $past(instr_end))
    else $error("service began off a boundary");
  step_clear_a: assert property ($fell(busy) && vector_ff == VEC_STEP
    |-> !status_word_ff[FLAG_STEP]) else $error("step flag left set");
  ien_clear_a: assert property ($fell(busy) |-> !status_word_ff[FLAG_IEN])
    else $error("interrupt enable left set");
endmodule
`default_nettype wire

// >>> bench/caiu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module caiu_bus_model
  import caiu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Requests from the core and the acknowledge vector
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_ack_cycle,
  input wire logic [19:0] bus_addr_ff,
  input wire logic [15:0] bus_wdata_ff,
  input wire logic [7:0] ack_vec,
  // Answers
  output logic bus_done,
  output logic [15:0] bus_rdata
);
  logic [1:0] wait_ff;
  logic slow_ff;
  logic [15:0] wr_log [0:2];
  int wr_idx;
  // Alternates prompt and three-cycle answers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wait_ff <= 2'h0;
      slow_ff <= 1'b0;
      bus_done <= 1'b0;
      bus_rdata <= 16'hFFFF;
      wr_idx <= 0;
    end else if (bus_req && !bus_done && wait_ff >= {slow_ff, 1'b0}) begin
      bus_done <= 1'b1;
      wait_ff <= 2'h0;
      slow_ff <= !slow_ff;
      if (bus_ack_cycle) bus_rdata <= {8'h00, ack_vec};
      else if (!bus_write) bus_rdata <= bus_addr_ff[15:0] + 16'h1000;
      if (bus_write) begin
        wr_log[wr_idx % 3] <= bus_wdata_ff;
        wr_idx <= wr_idx + 1;
      end
    end else begin
      bus_done <= 1'b0;
      // Stale data must not look valid
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_done) wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> bench/cpu_address_and_interrupt_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_address_and_interrupt_unit_test
  import caiu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  caiu_acc_t acc_kind;
  caiu_seg_t override_seg, seg_used_ff;
  caiu_disp_t disp_kind;
  logic bp_base, override_en, base_en, base_sel_bp, index_en, index_sel_di, port_from_reg;
  logic instr_end, divide_overflow, escape_trap, escape_has_prefix, soft_int, other_exc;
  logic step_skip, nmi_req, intr_req, intr_internal, flags_wr, cs_wr;
  logic bus_req, bus_write, bus_ack_cycle, bus_done, busy;
  logic [7:0] port_imm, soft_type, other_exc_type, intr_internal_type, vector_ff, ack_vec;
  logic [15:0] disp, base_general_reg, base_pointer_reg, source_index_reg;
  logic [15:0] destination_index_reg, extra_segment_reg, stack_segment_reg, data_segment_reg;
  logic [15:0] eff_addr_ff, port_addr_ff, port_number_reg, next_ip, instr_start_ip, prefix_ip;
  logic [15:0] flags_wdata, cs_wdata, bus_wdata_ff, bus_rdata, status_word_ff, code_segment_ff;
  logic [15:0] instruction_pointer_ff, stack_ptr_ff, cur_flags, cur_cs, sp_exp;
  logic [19:0] mem_addr_ff, bus_addr_ff;
  int errors = 0;
  int comparisons = 0;

  caiu_core dut (.*);
  caiu_bus_model u_bus (.*);

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic addr(input caiu_acc_t k, input logic ov, input caiu_disp_t dk,
      input logic [15:0] d, input logic [3:0] sel, input caiu_seg_t es, input logic [15:0] ea);
    logic [15:0] sv;
    @(posedge ref_clk);
    acc_kind <= k;
    override_en <= ov;
    disp_kind <= dk;
    disp <= d;
    {base_en, base_sel_bp, index_en, index_sel_di} <= sel;
    bp_base <= sel[3] & sel[2];
    @(posedge ref_clk);
    #1;
    sv = es == SEG_CODE ? cur_cs : es == SEG_STACK ? stack_segment_reg :
      es == SEG_EXTRA ? extra_segment_reg : data_segment_reg;
    chk(seg_used_ff, es);
    chk(eff_addr_ff, ea);
    chk(mem_addr_ff, {sv, 4'h0} + ea);
  endtask

  task automatic port(input logic r, input logic [15:0] exp);
    @(posedge ref_clk);
    port_from_reg <= r;
    @(posedge ref_clk);
    #1;
    chk(port_addr_ff, exp);
  endtask

  task automatic wf(input logic [15:0] v);
    @(posedge ref_clk);
    flags_wr <= 1'b1;
    flags_wdata <= v;
    @(posedge ref_clk);
    flags_wr <= 1'b0;
    cur_flags = v;
  endtask

  // Codes 9 and up must be refused
  task automatic fire(input int k, input logic [7:0] ev, input logic [15:0] ret);
    int n;
    @(posedge ref_clk);
    instr_end <= 1'b1;
    divide_overflow <= k == 0;
    escape_trap <= k == 1;
    escape_has_prefix <= k == 1;
    other_exc <= k == 2;
    soft_int <= k == 3 || k == 6;
    nmi_req <= k == 5;
    intr_req <= k >= 6 && k != 9;
    intr_internal <= k == 7;
    step_skip <= k == 9;
    @(posedge ref_clk);
    {instr_end, divide_overflow, escape_trap, other_exc, soft_int, nmi_req, intr_req} <= '0;
    #1;
    if (k >= 9) begin
      chk(busy, 1'b0);
      return;
    end
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(busy, 1'b0);
    chk(vector_ff, ev);
    chk(u_bus.wr_log[0], cur_flags);
    chk(u_bus.wr_log[1], cur_cs);
    chk(u_bus.wr_log[2], ret);
    sp_exp = sp_exp - 16'h0006;
    chk(stack_ptr_ff, sp_exp);
    cur_cs = {ev, 2'b10} + 16'h1000;
    chk(instruction_pointer_ff, {ev, 2'b00} + 16'h1000);
    chk(code_segment_ff, cur_cs);
    cur_flags = cur_flags & 16'hFCFF;
    chk(status_word_ff, cur_flags);
  endtask

  initial begin
    {bp_base, override_en, base_en, base_sel_bp, index_en, index_sel_di, port_from_reg} = '0;
    {instr_end, divide_overflow, escape_trap, escape_has_prefix, soft_int, other_exc} = '0;
    {step_skip, nmi_req, intr_req, intr_internal, flags_wr, cs_wr} = '0;
    {disp, flags_wdata, cs_wdata} = '0;
    acc_kind = ACC_DATA;
    override_seg = SEG_EXTRA;
    disp_kind = DISP_NONE;
    {base_general_reg, base_pointer_reg} = {16'h1234, 16'hF000};
    {source_index_reg, destination_index_reg} = {16'h0010, 16'h8000};
    {extra_segment_reg, stack_segment_reg, data_segment_reg} = {16'h1000, 16'h2000, 16'h3000};
    {next_ip, instr_start_ip, prefix_ip} = {16'h0200, 16'h01FC, 16'h01FB};
    {soft_type, intr_internal_type, ack_vec} = {8'h80, 8'h21, 8'h40};
    other_exc_type = 8'h05;
    port_imm = 8'hE9;
    port_number_reg = 16'hABCD;
    cur_flags = FLAGS_RST;
    cur_cs = CS_RST;
    sp_exp = SP_RST;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    addr(ACC_FETCH, 1'b1, DISP_16, 16'h0100, 4'h0, SEG_CODE, 16'h0100);
    addr(ACC_STACK, 1'b0, DISP_NONE, 16'h0000, 4'h0, SEG_STACK, 16'h0000);
    addr(ACC_DATA, 1'b0, DISP_8, 16'hABF0, 4'hC, SEG_STACK, 16'hEFF0);
    addr(ACC_STRING_DST, 1'b0, DISP_NONE, 16'h0000, 4'h3, SEG_EXTRA, 16'h8000);
    addr(ACC_DATA, 1'b0, DISP_16, 16'hFFFF, 4'hA, SEG_DATA, 16'h1243);
    addr(ACC_DATA, 1'b1, DISP_8, 16'h007F, 4'h0, SEG_EXTRA, 16'h007F);
    addr(ACC_DATA, 1'b0, DISP_NONE, 16'h0000, 4'h2, SEG_DATA, 16'h0010);
    addr(ACC_DATA, 1'b0, DISP_8, 16'h0080, 4'h3, SEG_DATA, 16'h7F80);
    addr(ACC_DATA, 1'b0, DISP_NONE, 16'h0000, 4'hF, SEG_STACK, 16'h7000);
    port(1'b0, 16'h00E9);
    port(1'b1, 16'hABCD);
    fire(0, VEC_DIVIDE, 16'h0200);
    fire(1, VEC_ESCAPE, 16'h01FB);
    fire(2, 8'h05, 16'h0200);
    fire(3, 8'h80, 16'h0200);
    wf(16'h0100);
    fire(4, VEC_STEP, 16'h0200);
    fire(5, VEC_NMI, 16'h0200);
    wf(16'h0200);
    fire(6, 8'h80, 16'h0200);
    wf(16'h0200);
    fire(7, 8'h21, 16'h0200);
    wf(16'h0200);
    fire(8, 8'h40, 16'h0200);
    fire(10, 8'h40, 16'h0200);
    wf(16'h0100);
    fire(9, VEC_STEP, 16'h0200);
    print_verdict();
  end

  // Whole run needs far fewer cycles than this
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule

bind caiu_core caiu_checker u_chk (.*);
`default_nettype wire
